// file: logic/buck_ctrl_params.svh
`ifndef BUCK_CTRL_PARAMS_SVH
`define BUCK_CTRL_PARAMS_SVH

// clock rate and documented times (ns)
`define CLK_MHZ 40
`define T_SS_INT_NS 1000000
`define T_SS_DISCHARGE_NS 500000
`define T_PG_RISE_NS 50000
`define T_PG_FALL_NS 10000
// cycles from times: a least time rounds up
`define NS_TO_CYC(ns) (((ns) * `CLK_MHZ + 999) / 1000)

// switching periods in clock cycles (40 MHz / fsw, rounded down)
`define DIV_500K 7'd80
`define DIV_1000K 7'd40
`define DIV_1500K 7'd26
`define DIV_2000K 7'd20

// fault handling counts
`define OCP_VALLEY_LIMIT 16
`define HICCUP_SS_PERIODS 7

// strap code fields
`define FREQ_FIELD_HI 3
`define FREQ_FIELD_LO 2
`define RAMP_FIELD_HI 1
`define RAMP_FIELD_LO 0
`define PHASE_CODE_TWO 4'h0
`define PHASE_CODE_D180_LO 4'h1
`define PHASE_CODE_D180_HI 4'h4
`define PHASE_CODE_D90_LO 4'h5
`define PHASE_CODE_D90_HI 4'h8

// register map (byte addresses)
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_FAULT 12'h008
`define CTRL_RESET 2'h3
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: logic/buck_ctrl_pkg.sv
package buck_ctrl_pkg;

	// emulated ramp capacitor choice
	typedef enum logic [1:0] {
		RAMP_1P5 = 2'b00,
		RAMP_2P5 = 2'b01,
		RAMP_4P0 = 2'b10,
		RAMP_6P0 = 2'b11
	} ramp_cap_t;

	// switching frequency choice
	typedef enum logic [1:0] {
		FSW_500K = 2'b00,
		FSW_1000K = 2'b01,
		FSW_1500K = 2'b10,
		FSW_2000K = 2'b11
	} freq_sel_t;

	// phase configuration
	typedef enum logic [1:0] {
		PM_TWO_PHASE = 2'b00,
		PM_DUAL_0_180 = 2'b01,
		PM_DUAL_90_270 = 2'b10
	} phase_mode_t;

	// per-rail start-up sequence
	typedef enum logic [1:0] {
		SS_OFF = 2'b00,
		SS_RAMP = 2'b01,
		SS_RUN = 2'b10,
		SS_HICCUP = 2'b11
	} ss_state_t;

	// analog comparator results of one rail
	typedef struct packed {
		logic pwm_demand;
		logic window_ok;
		logic valley_over;
		logic peak_hit;
		logic neg_over;
	} rail_sense_t;

	// gate commands of one rail
	typedef struct packed {
		logic hs;
		logic ls;
	} gate_drive_t;

endpackage

// file: logic/buck_softstart_fault_ctrl.sv
`timescale 1ns/10ps
`include "buck_ctrl_params.svh"
// Operation
// (RL1) four ramp capacitor settings per rail
// (RL2) frequency strap gives four switching frequencies
// (RL3) ramp order within group: 1.5/2.5/4/6
// (RL4) dual mode: rail two ramp from phase strap
// (RL5) board: 1.5 pF up to 4 V
// (RL6) dual mode: fixed 1 ms internal soft start
// (RL7) board: leave soft-start pin open in dual
// (RL8) multi-phase: 2 uA charges external capacitor
// (RL9) discharge soft-start capacitor 500 us on stop
// (RL10) leftover charge: internal ramp, then capacitor ramp
// (RL11) power-good inactive until soft start completes
// (RL12) power-good rises 50 us after window good
// (RL13) power-good falls 10 us after leaving window
// (RL14) power-good works while input above 1.5 V
// (RL15) overcurrent acted on only after soft start
// (RL16) valley overcurrent skips pulse, counts up
// (RL17) valley counter clears below limit
// (RL18) sixteen valley cycles means fault, hiccup
// (RL19) hiccup waits seven soft-start periods
// (RL20) peak limit: high side off until valley
// (RL21) negative limit: low side off until clock
// (RL22) phase strap decodes mode and phase
// (RL23) straps latched once after supply valid
// (RL24) soft-start complete gates power-good and overcurrent
module buck_softstart_fault_ctrl #(
	parameter int ADDR_W = 12,
	parameter int SS_CYCLES = `NS_TO_CYC(`T_SS_INT_NS),
	parameter int DIS_CYCLES = `NS_TO_CYC(`T_SS_DISCHARGE_NS)
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// supplies, enables and straps
	input wire logic supply_ok,
	input wire logic power_stage_input_ok,
	input wire logic [1:0] rail_enable,
	input wire logic [3:0] phase_config_strap,
	input wire logic [3:0] freq_ramp_strap,
	// analog comparators
	input wire buck_ctrl_pkg::rail_sense_t [1:0] sense,
	input wire logic ss_cap_leftover,
	input wire logic ss_cap_at_target,
	// power stage and ramp controls
	output buck_ctrl_pkg::gate_drive_t [1:0] gate,
	output buck_ctrl_pkg::ramp_cap_t [1:0] ramp_cap,
	output buck_ctrl_pkg::freq_sel_t freq_sel,
	output logic ss_charge_on,
	output logic ss_discharge_on,
	output logic ref_from_cap,
	// open-drain power-good pins
	input wire logic rail_one_ok_flag_in,
	output logic rail_one_ok_flag_out,
	output logic rail_one_ok_flag_oe,
	input wire logic rail_two_ok_flag_in,
	output logic rail_two_ok_flag_out,
	output logic rail_two_ok_flag_oe
);
	import buck_ctrl_pkg::*;

	localparam int PG_RISE = `NS_TO_CYC(`T_PG_RISE_NS);
	localparam int PG_FALL = `NS_TO_CYC(`T_PG_FALL_NS);
	localparam int HIC_CYCLES = `HICCUP_SS_PERIODS * SS_CYCLES;
	localparam int CW = $clog2(HIC_CYCLES + 1);
	localparam int DW = $clog2(DIS_CYCLES + 1);
	localparam int PW = $clog2(PG_RISE + 1);

	// the counters are sized from these and the decode reads twelve address bits
	if (SS_CYCLES < 2 || DIS_CYCLES < 1 || ADDR_W < 12) begin : g_bad_param
		$error("unsupported parameter value");
	end

	// frequency strap: two bits of frequency, two of ramp (see RL2) (see RL3)
	function automatic freq_sel_t strap_freq(input logic [3:0] code);
		return freq_sel_t'(code[`FREQ_FIELD_HI:`FREQ_FIELD_LO]);
	endfunction

	function automatic ramp_cap_t strap_ramp(input logic [3:0] code);
		return ramp_cap_t'(code[`RAMP_FIELD_HI:`RAMP_FIELD_LO]);
	endfunction

	// phase strap: codes above the table fall back to dual 0/180 (see RL22)
	function automatic phase_mode_t strap_phase(input logic [3:0] code);
		if (code == `PHASE_CODE_TWO)
			return PM_TWO_PHASE;
		if (code >= `PHASE_CODE_D90_LO && code <= `PHASE_CODE_D90_HI)
			return PM_DUAL_90_270;
		return PM_DUAL_0_180;
	endfunction

	// rail two ramp from the phase strap, per group of four (see RL4)
	function automatic ramp_cap_t phase_ramp(input logic [3:0] code);
		logic [3:0] idx;
		idx = (code >= `PHASE_CODE_D90_LO) ? code - `PHASE_CODE_D90_LO
			: code - `PHASE_CODE_D180_LO;
		return ramp_cap_t'(idx[1:0]);
	endfunction

	logic strap_valid_q;
	freq_sel_t freq_q;
	phase_mode_t mode_q;
	ramp_cap_t [1:0] ramp_q;
	logic multi;

	// straps are sampled once per power-up; collapse of supply rearms (see RL23)
	always_ff @(posedge aclk) begin
		if (!aresetn || !supply_ok) begin
			strap_valid_q <= 1'b0;
			freq_q <= FSW_500K;
			mode_q <= PM_DUAL_0_180;
			ramp_q[0] <= RAMP_1P5;
			ramp_q[1] <= RAMP_1P5;
		end else if (!strap_valid_q) begin
			strap_valid_q <= 1'b1;
			freq_q <= strap_freq(freq_ramp_strap); // see RL2
			mode_q <= strap_phase(phase_config_strap); // see RL22
			ramp_q[0] <= strap_ramp(freq_ramp_strap); // see RL1
			ramp_q[1] <= (strap_phase(phase_config_strap) == PM_TWO_PHASE)
				? strap_ramp(freq_ramp_strap) : phase_ramp(phase_config_strap); // see RL4
		end
	end

	assign multi = (mode_q == PM_TWO_PHASE);
	assign freq_sel = freq_q;
	assign ramp_cap = ramp_q;

	// switching clock: one enable pulse per period and rail, phase shifted
	logic [6:0] div_q;
	logic [6:0] period;
	logic [6:0] off0;
	logic [6:0] off1;
	logic [1:0] tick;

	always_comb begin
		unique case (freq_q)
			FSW_500K: period = `DIV_500K;
			FSW_1000K: period = `DIV_1000K;
			FSW_1500K: period = `DIV_1500K;
			FSW_2000K: period = `DIV_2000K;
		endcase
		if (mode_q == PM_DUAL_90_270) begin
			off0 = period >> 2;
			off1 = period - (period >> 2);
		end else begin
			off0 = 7'h00;
			off1 = period >> 1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !strap_valid_q || div_q >= period - 7'h01)
			div_q <= 7'h00;
		else
			div_q <= div_q + 7'h01;
	end

	assign tick[0] = strap_valid_q && (div_q == off0);
	assign tick[1] = strap_valid_q && (div_q == off1);

	// software enables
	logic [1:0] ctrl_q;
	logic [1:0] fault_q;

	ss_state_t [1:0] state_q;
	logic [1:0][CW-1:0] ss_cnt_q;
	logic [1:0] ss_done;
	logic [1:0] en;
	logic [1:0] fault_evt;
	logic [1:0][4:0] vcnt_q;
	logic [1:0] skip_q;
	logic [1:0] peak_block_q;
	logic [1:0] neg_block_q;
	gate_drive_t [1:0] gate_q;
	logic [1:0] pg_q;
	logic [1:0][PW-1:0] pg_cnt_q;
	logic ref_cap_q;
	logic [DW-1:0] dis_cnt_q;

	// in two-phase operation rail two runs from rail one's enable
	assign en[0] = strap_valid_q && supply_ok && rail_enable[0] && ctrl_q[0];
	assign en[1] = strap_valid_q && supply_ok && ctrl_q[1]
		&& (multi ? rail_enable[0] : rail_enable[1]);

	genvar r;
	generate
		for (r = 0; r < 2; r++) begin : g_rail
			logic int_done;
			logic ramp_done;
			logic use_cap;

			// rail one sets the external capacitor ramp in multi-phase mode
			assign use_cap = multi && (r == 0);
			assign int_done = (ss_cnt_q[r] >= CW'(SS_CYCLES - 1));
			// ramp ends on internal timer, or on capacitor once it leads
			assign ramp_done = (use_cap && ref_cap_q) ? ss_cap_at_target : int_done; // see RL10
			assign ss_done[r] = (state_q[r] == SS_RUN); // see RL24

			// soft start, run and hiccup sequence
			always_ff @(posedge aclk) begin
				if (!aresetn || !en[r]) begin
					state_q[r] <= SS_OFF;
					ss_cnt_q[r] <= '0;
				end else begin
					unique case (state_q[r])
						SS_OFF: begin
							state_q[r] <= SS_RAMP;
							ss_cnt_q[r] <= '0;
						end
						SS_RAMP: begin
							if (ramp_done) begin
								state_q[r] <= SS_RUN; // see RL6
								ss_cnt_q[r] <= '0;
							end else if (!int_done) begin
								ss_cnt_q[r] <= ss_cnt_q[r] + 1'b1;
							end
						end
						SS_RUN: begin
							if (fault_evt[r]) begin
								state_q[r] <= SS_HICCUP; // see RL18
								ss_cnt_q[r] <= '0;
							end
						end
						SS_HICCUP: begin
							if (ss_cnt_q[r] >= CW'(HIC_CYCLES - 1)) begin
								state_q[r] <= SS_RAMP; // see RL19
								ss_cnt_q[r] <= '0;
							end else begin
								ss_cnt_q[r] <= ss_cnt_q[r] + 1'b1;
							end
						end
					endcase
				end
			end

			// valley counting only once soft start is done
			assign fault_evt[r] = ss_done[r] && tick[r] && sense[r].valley_over
				&& (vcnt_q[r] == 5'(`OCP_VALLEY_LIMIT - 1)); // see RL18

			always_ff @(posedge aclk) begin
				if (!aresetn || !ss_done[r]) begin
					vcnt_q[r] <= 5'h00; // see RL15
					skip_q[r] <= 1'b0;
				end else if (tick[r]) begin
					if (sense[r].valley_over) begin
						vcnt_q[r] <= fault_evt[r] ? 5'h00 : vcnt_q[r] + 5'h01; // see RL16
						skip_q[r] <= 1'b1;
					end else begin
						vcnt_q[r] <= 5'h00; // see RL17
						skip_q[r] <= 1'b0;
					end
				end
			end

			// peak hold-off lasts until a clock edge finds current below valley
			always_ff @(posedge aclk) begin
				if (!aresetn || !ss_done[r])
					peak_block_q[r] <= 1'b0;
				else if (sense[r].peak_hit)
					peak_block_q[r] <= 1'b1; // see RL20
				else if (tick[r] && !sense[r].valley_over)
					peak_block_q[r] <= 1'b0; // see RL20
			end

			// negative limit releases at the next switching pulse
			always_ff @(posedge aclk) begin
				if (!aresetn || !ss_done[r])
					neg_block_q[r] <= 1'b0;
				else if (sense[r].neg_over)
					neg_block_q[r] <= 1'b1; // see RL21
				else if (tick[r])
					neg_block_q[r] <= 1'b0; // see RL21
			end

			// registered gates; never both on
			always_ff @(posedge aclk) begin
				if (!aresetn || !(state_q[r] == SS_RAMP || ss_done[r])) begin
					gate_q[r] <= '0;
				end else begin
					gate_q[r].hs <= sense[r].pwm_demand && !skip_q[r] && !peak_block_q[r];
					gate_q[r].ls <= !(sense[r].pwm_demand && !skip_q[r] && !peak_block_q[r])
						&& !neg_block_q[r]; // see RL16
				end
			end

			// power-good qualification with asymmetric delays
			always_ff @(posedge aclk) begin
				if (!aresetn || !ss_done[r] || !power_stage_input_ok) begin
					pg_q[r] <= 1'b0; // see RL11
					pg_cnt_q[r] <= '0; // see RL14
				end else if (pg_q[r] == sense[r].window_ok) begin
					pg_cnt_q[r] <= '0;
				end else if (!pg_q[r] && pg_cnt_q[r] >= PW'(PG_RISE - 1)) begin
					pg_q[r] <= 1'b1; // see RL12
					pg_cnt_q[r] <= '0;
				end else if (pg_q[r] && pg_cnt_q[r] >= PW'(PG_FALL - 1)) begin
					pg_q[r] <= 1'b0; // see RL13
					pg_cnt_q[r] <= '0;
				end else begin
					pg_cnt_q[r] <= pg_cnt_q[r] + 1'b1;
				end
			end
		end
	endgenerate

	assign gate = gate_q;

	// which ramp leads: set once the capacitor overtakes the internal ramp
	always_ff @(posedge aclk) begin
		if (!aresetn || state_q[0] != SS_RAMP || !multi)
			ref_cap_q <= 1'b0;
		else if (ss_cap_leftover)
			ref_cap_q <= 1'b1; // see RL10
	end

	// capacitor discharge after stop or fault; a restart cuts it short
	always_ff @(posedge aclk) begin
		if (!aresetn)
			dis_cnt_q <= '0;
		else if (multi && (state_q[0] == SS_RAMP || state_q[0] == SS_RUN)
			&& (!en[0] || fault_evt[0]))
			dis_cnt_q <= DW'(DIS_CYCLES); // see RL9
		else if (state_q[0] == SS_RAMP || !multi)
			dis_cnt_q <= '0;
		else if (dis_cnt_q != '0)
			dis_cnt_q <= dis_cnt_q - 1'b1;
	end

	// 2 uA source enabled only for the multi-phase ramp (see RL8)
	assign ss_charge_on = multi && (state_q[0] == SS_RAMP);
	assign ss_discharge_on = (dis_cnt_q != '0);
	assign ref_from_cap = ref_cap_q;

	// open drain: drive low unless good
	assign rail_one_ok_flag_out = 1'b0;
	assign rail_two_ok_flag_out = 1'b0;
	assign rail_one_ok_flag_oe = !pg_q[0];
	assign rail_two_ok_flag_oe = !pg_q[1];

	// axi4-lite slave: address and data accepted in either order
	logic aw_got_q;
	logic w_got_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_go;
	logic [1:0] fault_clr;

	assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
	assign s_axi_wready = !w_got_q && !s_axi_bvalid;
	assign wr_go = aw_got_q && w_got_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q[11:0] == `REG_CTRL || awaddr_q[11:0] == `REG_FAULT)
					? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign fault_clr = (wr_go && awaddr_q[11:0] == `REG_FAULT && wstrb_q[0])
		? wdata_q[1:0] : 2'b00;

	// control register
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl_q <= `CTRL_RESET;
		else if (wr_go && awaddr_q[11:0] == `REG_CTRL && wstrb_q[0])
			ctrl_q <= wdata_q[1:0];
	end

	// sticky fault flags: a new fault wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn)
			fault_q <= 2'b00;
		else
			fault_q <= (fault_q & ~fault_clr) | fault_evt;
	end

	// read path, one cycle latency
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			unique case (s_axi_araddr[11:0])
				`REG_CTRL: s_axi_rdata <= {30'h00000000, ctrl_q};
				`REG_STATUS: s_axi_rdata <= {12'h000, state_q[1], state_q[0],
					ss_discharge_on, rail_two_ok_flag_in, rail_one_ok_flag_in, pg_q,
					ss_done, strap_valid_q, mode_q, ramp_q[1], ramp_q[0], freq_q};
				`REG_FAULT: s_axi_rdata <= {30'h00000000, fault_q};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	assign s_axi_arready = !s_axi_rvalid;

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [15:0] win_run_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || !ss_done[0] || !power_stage_input_ok || !sense[0].window_ok)
			win_run_q <= 16'h0000;
		else if (win_run_q != 16'hFFFF)
			win_run_q <= win_run_q + 16'h0001;
	end

	sequence valley_tick_s;
		ss_done[0] && tick[0] && sense[0].valley_over;
	endsequence
	sequence ramp_finish_s;
		$rose(ss_done[0]) && !multi;
	endsequence

	strap_hold_a: assert property (strap_valid_q && $past(strap_valid_q) |-> $stable(freq_q)
		&& $stable(mode_q)) else $error("strap decode changed"); // see RL23
	pg_gate_a: assert property (!ss_done[0] |=> !pg_q[0])
		else $error("power-good before soft start"); // see RL11
	pg_rise_a: assert property ($rose(pg_q[0]) |-> win_run_q >= 16'(PG_RISE))
		else $error("power-good rose early"); // see RL12
	pg_fall_a: assert property (pg_q[0] && !sense[0].window_ok && ss_done[0] && power_stage_input_ok
		[*8] |-> pg_q[0]) else $error("power-good fell early"); // see RL13
	power_stage_input_pg_a: assert property (!power_stage_input_ok |=> !pg_q[0])
		else $error("power-good with low input"); // see RL14
	valley_skip_a: assert property (valley_tick_s ##1 ss_done[0] |-> ##1 !gate_q[0].hs)
		else $error("pulse not skipped"); // see RL16
	valley_clear_a: assert property (ss_done[0] && tick[0] && !sense[0].valley_over
		|=> vcnt_q[0] == 5'h00) else $error("valley count kept"); // see RL17
	ocp_hiccup_a: assert property (fault_evt[0] && en[0] |=> state_q[0] == SS_HICCUP)
		else $error("no hiccup on fault"); // see RL18
	neg_block_a: assert property (ss_done[0] && sense[0].neg_over |=> neg_block_q[0])
		else $error("low side not blocked"); // see RL21
	ss_time_a: assert property (ramp_finish_s |-> $past(ss_cnt_q[0]) == CW'(SS_CYCLES - 1))
		else $error("internal soft start length"); // see RL6

endmodule

// file: verification/buck_softstart_fault_ctrl_tb.sv
`timescale 1ns/10ps
`include "buck_ctrl_params.svh"
module buck_softstart_fault_ctrl_tb;
	import buck_ctrl_pkg::*;
	// short soft-start counts keep the run brief; expectations follow them
	localparam int SS = 20;
	localparam int DIS = 10;
	localparam int P = 80;
	localparam int PG_RISE = 50000 / 25;
	localparam int PG_FALL = 10000 / 25;
	localparam int LIMIT = 30000;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int dis_n = 0;
	int n, ph, hs_seen;
	logic [31:0] d, m, e, seed;
	logic [1:0] r;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic supply_ok = 1'h0, power_stage_input_ok = 1'h1, leftover = 1'h0, at_target = 1'h0;
	logic [1:0] rail_en = 2'h0, in_window = 2'h0, valley = 2'h0, peak = 2'h0, neg = 2'h0;
	logic [3:0] pstrap = 4'h0, fstrap = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, ss_charge, ss_dis, ref_cap;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic ok1_in, ok1_out, ok1_oe, ok2_in, ok2_out, ok2_oe;
	rail_sense_t [1:0] sense;
	gate_drive_t [1:0] gate;
	ramp_cap_t [1:0] ramp_cap;
	freq_sel_t freq_sel;

	buck_softstart_fault_ctrl #(.SS_CYCLES(SS), .DIS_CYCLES(DIS)) i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.supply_ok(supply_ok), .power_stage_input_ok(power_stage_input_ok), .rail_enable(rail_en),
		.phase_config_strap(pstrap), .freq_ramp_strap(fstrap), .sense(sense),
		.ss_cap_leftover(leftover), .ss_cap_at_target(at_target), .gate(gate),
		.ramp_cap(ramp_cap), .freq_sel(freq_sel), .ss_charge_on(ss_charge),
		.ss_discharge_on(ss_dis), .ref_from_cap(ref_cap),
		.rail_one_ok_flag_in(ok1_in), .rail_one_ok_flag_out(ok1_out),
		.rail_one_ok_flag_oe(ok1_oe), .rail_two_ok_flag_in(ok2_in),
		.rail_two_ok_flag_out(ok2_out), .rail_two_ok_flag_oe(ok2_oe)
	);

	stage_model i_stage (
		.in_window(in_window), .valley(valley), .peak(peak), .neg(neg), .gate(gate),
		.sense(sense), .ok1_oe(ok1_oe), .ok2_oe(ok2_oe), .ok1_in(ok1_in), .ok2_in(ok2_in)
	);

	always #12.5 aclk = ~aclk;

	// cycle count, discharge time and hang guard
	always @(posedge aclk) begin
		cycles++;
		if (ss_dis === 1'h1) dis_n++;
		if (cycles == LIMIT) begin
			errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
		end
	endtask

	task automatic in_range(input int v, input int lo, input int hi, input string s);
		num_checks++;
		if (v < lo || v > hi) begin
			errors++;
			$display("unexpected at %0t: %s took %0d cycles", $time, s, v);
		end
	endtask

	// bus tasks start just after a rising edge; ready is looked at before the edge
	task automatic axw(input logic [11:0] a, input logic [31:0] dat, output logic [1:0] rs);
		logic aw_ok, w_ok, b_ok;
		awaddr <= a;
		wdata <= dat;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(negedge aclk);
			aw_ok = awvalid && awready;
			w_ok = wvalid && wready;
			b_ok = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (aw_ok) awvalid <= 1'h0;
			if (w_ok) wvalid <= 1'h0;
		end while (!b_ok);
		bready <= 1'h0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] rs);
		logic a_ok, r_ok;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(negedge aclk);
			a_ok = arvalid && arready;
			r_ok = rvalid;
			dat = rdata;
			rs = rresp;
			@(posedge aclk);
			if (a_ok) arvalid <= 1'h0;
		end while (!r_ok);
		rready <= 1'h0;
		@(posedge aclk);
	endtask

	// power cycle the straps; the later strap change must not be followed
	task automatic restrap(input int p, input int f);
		supply_ok <= 1'h0;
		pstrap <= p[3:0];
		fstrap <= f[3:0];
		repeat (2) @(posedge aclk);
		supply_ok <= 1'h1;
		repeat (3) @(posedge aclk);
		pstrap <= ~p[3:0];
		fstrap <= ~f[3:0];
		repeat (2) @(posedge aclk);
	endtask

	task automatic wait_state(input logic [1:0] st, output int t);
		int t0;
		t0 = cycles;
		do rd(`REG_STATUS, d, r);
		while (d[17:16] !== st && cycles - t0 < 5000);
		t = cycles - t0;
		chk(d[17:16], st, "state not reached");
	endtask

	function automatic logic probe(input int k);
		return (k == 0) ? ok1_in : gate[0].hs;
	endfunction

	task automatic wait_for(input int k, input logic v, input int lim, output int t);
		t = 0;
		while (probe(k) !== v && t < lim) begin
			@(negedge aclk);
			t++;
		end
		@(posedge aclk);
	endtask

	// expected status low bits: freq, ramp one, ramp two, mode, strap valid
	function automatic logic [31:0] strap_model(input int f, input int p);
		int mode;
		mode = (p == 0) ? 0 : (p <= 4) ? 1 : 2;
		return (f >> 2) | ((f & 3) << 2) | (((p - 1) & 3) << 4) | (mode << 6) | 256;
	endfunction

	initial begin
		seed = $urandom(32'hAD2E);
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(`REG_CTRL, d, r);
		chk(d, 32'h3, "ctrl reset");
		rd(`REG_FAULT, d, r);
		chk(d, 32'h0, "fault reset");
		rd(12'h00C, d, r);
		chk({d[29:0], r}, {30'h0, `RESP_SLVERR}, "unmapped read");
		axw(12'h00C, 32'hFFFFFFFF, r);
		chk(r, `RESP_SLVERR, "unmapped write");
		// every frequency code once, phase codes 0 to 8, then random ones
		for (int i = 0; i < 16; i++) begin
			ph = (i < 9) ? i : $urandom_range(8, 0);
			restrap(ph, i);
			m = (ph == 0) ? 32'h1CF : 32'h1FF;
			e = strap_model(i, ph);
			rd(`REG_STATUS, d, r);
			chk(d[8:0] & m, e & m, "strap status");
			chk({ramp_cap[1], ramp_cap[0], freq_sel} & m, e[5:0] & m, "strap pins");
		end
		// dual output low rail, cap pin left open: internal start then power-good
		restrap(1, 0);
		in_window <= 2'h3;
		rail_en <= 2'h1;
		repeat (2) @(posedge aclk);
		chk(ss_charge, 1'h0, "cap charged in dual");
		wait_for(0, 1'h1, 5000, n);
		in_range(n + 2, SS + PG_RISE, SS + PG_RISE + 8, "flag rise");
		chk(ok2_in, 1'h0, "idle rail flag");
		chk({ok1_out, ok2_out}, 2'h0, "open drain drive");
		chk(gate[1], 2'h0, "idle rail gates");
		in_window <= 2'h2;
		wait_for(0, 1'h0, 1000, n);
		in_range(n, PG_FALL, PG_FALL + 5, "flag fall");
		in_window <= 2'h3;
		wait_for(0, 1'h1, 5000, n);
		power_stage_input_ok <= 1'h0;
		repeat (3) @(posedge aclk);
		chk(ok1_in, 1'h0, "flag without input");
		power_stage_input_ok <= 1'h1;
		// sustained valley overcurrent: skipped pulses, fault, hiccup, restart
		valley <= 2'h1;
		repeat (2 * P) @(posedge aclk);
		hs_seen = 0;
		repeat (P) begin
			@(negedge aclk);
			if (gate[0].hs !== 1'h0 || gate[0].ls !== 1'h1) hs_seen++;
		end
		@(posedge aclk);
		chk(hs_seen, 0, "pulse not skipped");
		wait_state(2'h3, n);
		in_range(n + 3 * P, 15 * P, 16 * P + 8, "fault count");
		valley <= 2'h0;
		rd(`REG_FAULT, d, r);
		chk(d, 32'h1, "fault flag");
		wait_state(2'h1, n);
		in_range(n, 7 * SS - 10, 7 * SS + 6, "hiccup wait");
		axw(`REG_FAULT, 32'h1, r);
		rd(`REG_FAULT, d, r);
		chk(d, 32'h0, "fault clear");
		wait_state(2'h2, n);
		// interrupted valley runs never reach the fault count
		repeat (3) begin
			valley <= 2'h1;
			repeat ($urandom_range(14 * P, 2 * P)) @(posedge aclk);
			valley <= 2'h0;
			repeat (2 * P) @(posedge aclk);
		end
		rd(`REG_FAULT, d, r);
		chk(d, 32'h0, "valley count cleared");
		// peak limit holds the high side off, negative limit drops the low side
		wait_for(1, 1'h1, 200, n);
		peak <= 2'h1;
		valley <= 2'h1;
		repeat (4) @(posedge aclk);
		chk({gate[0].hs, gate[0].ls}, 2'h1, "peak cut");
		neg <= 2'h1;
		peak <= 2'h0;
		repeat (3) @(posedge aclk);
		chk(gate[0].ls, 1'h0, "negative cut");
		neg <= 2'h0;
		valley <= 2'h0;
		wait_for(1, 1'h1, P + 4, n);
		in_range(n, 0, P + 3, "high side back");
		// two-phase start from the external capacitor, then its discharge
		restrap(0, 4);
		chk({ss_charge, ref_cap}, 2'h2, "cap charging");
		leftover <= 1'h1;
		repeat (3) @(posedge aclk);
		chk(ref_cap, 1'h1, "reference from cap");
		at_target <= 1'h1;
		wait_state(2'h2, n);
		dis_n = 0;
		leftover <= 1'h0;
		at_target <= 1'h0;
		axw(`REG_CTRL, 32'h0, r);
		repeat (3 * DIS) @(posedge aclk);
		in_range(dis_n, DIS, DIS + 1, "discharge time");
		finish_test();
	end
endmodule

// file: verification/stage_model.sv
`timescale 1ns/10ps
// power stage, inductor, load and power-good pull-ups seen by the controller
module stage_model
	import buck_ctrl_pkg::*;
(
	// current and window conditions set by the bench
	input wire logic [1:0] in_window,
	input wire logic [1:0] valley,
	input wire logic [1:0] peak,
	input wire logic [1:0] neg,
	// controller side
	input wire buck_ctrl_pkg::gate_drive_t [1:0] gate,
	output buck_ctrl_pkg::rail_sense_t [1:0] sense,
	input wire logic ok1_oe,
	input wire logic ok2_oe,
	output logic ok1_in,
	output logic ok2_in
);
	// heavy load keeps asking for full duty, so any gate block shows at once
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			sense[i] = {1'h1, in_window[i], valley[i], peak[i], neg[i]};
		end
	end

	// pull-up resistors: a released pin reads high, never the last driven value
	assign ok1_in = ok1_oe ? 1'h0 : 1'h1;
	assign ok2_in = ok2_oe ? 1'h0 : 1'h1;
endmodule
